// ==== core/reset_trap_pkg.sv ====
// Constants, encodings and register map for the reset trap sequencer.
// Contract
// - During power reset the drive control outputs go to a safe state.
// - All three reset traps enter one routine that ends in the idle loop.
// - Any reset trap aborts work and sets the abnormal-completion status bit.
// - I/O reset drives general interface reset without waiting for the clock.
// - I/O reset is latched, synchronised, then treated like other interrupts.
// - Synced abort gives group select, vector 000; jump on next edge.
// - Datapath byte clocks are suppressed while the trap is active.
// - During a trap the select code is 101100 with carry-in 0; push and jump.
// - Trap gates only datapath clocks; sequencer keeps running.
// - The jump edge also releases the trap, so it lasts one clock.
// - After the jump the datapath clocks run again for the first instruction.
// - Second trap instruction tests a board jumper to choose the self-test.
// - A clock-stop microword bit suppresses the next datapath clock.
// - On I/O reset release a quiet-window pulse clears the interrupt latch.
// - Power-fail warning traps the same way but gives no interface reset.
// - Power-fail warning has first priority in the encoder.
// - With no trap the datapath takes the function code and executes.
// - Vectors by priority: abort 000, then 010, 020, 030, 040.
// - Power reset clears the microprogram address, keeps the return entry and holds vector 000.
package reset_trap_pkg;
	localparam int          CLK_PERIOD_NS  = 40;
	localparam int          TRAP_PERIOD_NS = 300;
	localparam int          TRAP_CYCLES    = (TRAP_PERIOD_NS / CLK_PERIOD_NS < 1) ? 1 : 1;
	localparam int          ADDR_W         = 9;
	localparam int          FUNC_W         = 7;
	localparam int          NUM_IRQ        = 4;
	// Sequencer select codes; the trap code is fixed by the address generator.
	localparam logic [5:0]  SEL_TRAP       = 6'h2c;
	localparam logic [5:0]  SEL_NEXT       = 6'h00;
	localparam logic [5:0]  SEL_JUMP       = 6'h04;
	localparam logic [5:0]  SEL_POP        = 6'h08;
	localparam logic [5:0]  SEL_PUSHJ      = 6'h0c;
	localparam logic        TRAP_CARRY     = 1'h0;
	localparam logic        SEQ_CARRY      = 1'h1;
	// Branch control field of the microword.
	typedef enum logic [2:0] {
		BR_CONTINUE = 3'h0,
		BR_JUMP     = 3'h1,
		BR_COND     = 3'h2,
		BR_RETURN   = 3'h3,
		BR_CALL     = 3'h4,
		BR_JUMPER   = 3'h5
	} branch_t;
	localparam logic [2:0]  VEC_ABORT      = 3'h0;
	localparam logic [8:0]  IDLE_ADDR      = 9'h1f9;
	localparam logic [8:0]  ADDR_ZERO      = 9'h000;
	// Register map, byte addresses of aligned words.
	localparam logic [7:0]  REG_CTRL       = 8'h00;
	localparam logic [7:0]  REG_STATUS     = 8'h04;
	localparam int          CTRL_JUMPER    = 0;
	localparam int          ST_ABNORMAL    = 0;
	localparam int          ST_ROUTINE     = 1;
	localparam int          ST_ABORT       = 2;
	localparam int          ST_ADDR_LSB    = 16;
	localparam logic        CTRL_RESET     = 1'h0;
endpackage

// ==== core/reset_trap_sequencer.sv ====
// Reset trap sequencer: abort latch, synchroniser, encoder, microsequencer, datapath clock gating.
`timescale 1ns/100ps
module reset_trap_sequencer (
	input  wire logic        clk_sys_in,                      // System and micro clock, 25 MHz.
	input  wire logic        rstn_in,                         // Asynchronous reset, active low.
	input  wire logic        power_reset_n_in,                // Backplane power reset, active low.
	input  wire logic        power_fail_warning_n_in,         // Backplane power-fail warning, active low.
	input  wire logic        io_reset_n_in,                   // Host I/O reset pulse, active low.
	input  wire logic [3:0]  irq_in,                          // Lower interrupt sources, same clock.
	input  wire logic        clock_stop_bit_in,               // Microword clock-stop bit.
	input  wire logic [6:0]  datapath_function_code_in,       // Microword datapath function code.
	input  wire logic [2:0]  branch_ctrl_in,                  // Microword branch control field.
	input  wire logic [8:0]  nra_field_in,                    // Microword next-address field.
	input  wire logic        test_bit_in,                     // Condition under test.
	input  wire logic        wb_cyc_in,                       // Wishbone cycle.
	input  wire logic        wb_stb_in,                       // Wishbone strobe.
	input  wire logic        wb_we_in,                        // Wishbone write enable.
	input  wire logic [7:0]  wb_adr_in,                       // Wishbone byte address.
	input  wire logic [3:0]  wb_sel_in,                       // Wishbone byte selects.
	input  wire logic [31:0] wb_dat_in,                       // Wishbone write data.
	output logic             wb_ack_out,                      // Wishbone acknowledge.
	output logic [31:0]      wb_dat_out,                      // Wishbone read data.
	output logic [8:0]       microprogram_address_out,        // Current microprogram address.
	output logic [5:0]       sequencer_select_code_out,       // Select code applied last edge.
	output logic             sequencer_carry_in_out,          // Carry applied last edge.
	output logic             datapath_left_byte_clock_n_out,  // Left byte clock strobe, active low.
	output logic             datapath_right_byte_clock_n_out, // Right byte clock strobe, active low.
	output logic [6:0]       datapath_function_code_out,      // Function code held by datapath.
	output logic             general_interface_reset_b_out,   // Interface reset, active high.
	output logic             device_ctrl_safe_out,            // Drive controls forced safe.
	output logic             interrupt_latch_clear_n_out,     // Interrupt latch clear, active low.
	output logic             clock_quiet_window_out           // Quiet window phase.
);

	////////////////////////////////////////////////////////////////////////////////
	logic        rst_meta_q, rst_n_q;
	logic        prst_n_meta_q, prst_n_sync_q, pfw_n_meta_q, pfw_n_sync_q, iors_n_meta_q, iors_n_sync_q;
	logic        abort_latched_n_q, abort_synced_n_q, trap_release_stage_n_q;
	logic        interrupt_latch_clear_n_q, clock_quiet_window_q;
	logic [8:0]  addr_q, stack_q;
	logic [5:0]  sel_code_q;
	logic        carry_q, left_n_q, right_n_q, gir_q, safe_q;
	logic [6:0]  func_q;
	logic        ack_q, jumper_q, abnormal_q, routine_q;
	logic [31:0] rdata_q;

	// Priority encoder: lowest index wins, index 0 is the abort source.
	function automatic logic [2:0] prio_encode(input logic [4:0] src);
		logic [2:0] code;
		code = 3'h7;
		for (int i = 4; i >= 0; i--) begin
			if (src[i]) begin
				code = 3'(i);
			end
		end
		return code;
	endfunction

	// Reset release through two flip-flops.
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rst_meta_q <= 1'b0;
			rst_n_q    <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q    <= rst_meta_q;
		end
	end

	// Backplane pins are asynchronous and pass two flip-flops before the trap logic; the interface reset and drive-safe flops take the raw pins.
	always_ff @(posedge clk_sys_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			prst_n_meta_q <= 1'b1;
			prst_n_sync_q <= 1'b1;
			pfw_n_meta_q  <= 1'b1;
			pfw_n_sync_q  <= 1'b1;
			iors_n_meta_q <= 1'b1;
			iors_n_sync_q <= 1'b1;
		end else begin
			prst_n_meta_q <= power_reset_n_in;
			prst_n_sync_q <= prst_n_meta_q;
			pfw_n_meta_q  <= power_fail_warning_n_in;
			pfw_n_sync_q  <= pfw_n_meta_q;
			iors_n_meta_q <= io_reset_n_in;
			iors_n_sync_q <= iors_n_meta_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Trap decode. Power reset forces the group select so the trap holds throughout.
	wire        pr_active      = !prst_n_sync_q;
	wire        abort_source   = !pfw_n_sync_q || !iors_n_sync_q;
	wire [4:0]  int_sources    = {irq_in, !abort_synced_n_q};
	wire [2:0]  abort_vector   = reset_trap_pkg::VEC_ABORT;
	wire        encoder_group_select = (|int_sources) || pr_active;
	wire [2:0]  interrupt_vector_code = pr_active ? abort_vector : prio_encode(int_sources);
	wire        trap           = encoder_group_select && trap_release_stage_n_q;
	wire        trap_zero_low_address = trap;
	wire [8:0]  next_microaddress = trap ? {2'h0, interrupt_vector_code, 4'h0} : nra_field_in;
	wire        abort_trap     = trap && (interrupt_vector_code == abort_vector);
	wire        latch_clear    = iors_n_sync_q && pfw_n_sync_q && !abort_latched_n_q &&
	                             encoder_group_select && clock_quiet_window_q;

	// Abort latch, its synchroniser stage and the trap release stage.
	always_ff @(posedge clk_sys_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			abort_latched_n_q      <= 1'b1;
			abort_synced_n_q       <= 1'b1;
			trap_release_stage_n_q <= 1'b1;
		end else begin
			// A new abort wins over a clear arriving in the same cycle.
			if (abort_source) begin
				abort_latched_n_q <= 1'b0;
			end else if (!interrupt_latch_clear_n_q || pr_active) begin
				abort_latched_n_q <= 1'b1;
			end
			abort_synced_n_q       <= abort_latched_n_q;
			trap_release_stage_n_q <= pr_active ? 1'b1 : !encoder_group_select;
		end
	end

	// Quiet window alternates each clock; the clear pulse is decided inside it and appears on the clock after.
	always_ff @(posedge clk_sys_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			clock_quiet_window_q      <= 1'b0;
			interrupt_latch_clear_n_q <= 1'b1;
		end else begin
			clock_quiet_window_q      <= !clock_quiet_window_q;
			interrupt_latch_clear_n_q <= !latch_clear;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Branch decode. The trap overrides every other input of the decoder.
	wire        test_ok  = (branch_ctrl_in == reset_trap_pkg::BR_JUMPER) ? jumper_q : test_bit_in;
	wire        is_cond  = (branch_ctrl_in == reset_trap_pkg::BR_COND) ||
	                       (branch_ctrl_in == reset_trap_pkg::BR_JUMPER);
	wire [5:0]  sel_d    = trap ? reset_trap_pkg::SEL_TRAP :
	                       (branch_ctrl_in == reset_trap_pkg::BR_JUMP)   ? reset_trap_pkg::SEL_JUMP :
	                       (branch_ctrl_in == reset_trap_pkg::BR_RETURN) ? reset_trap_pkg::SEL_POP :
	                       (branch_ctrl_in == reset_trap_pkg::BR_CALL)   ? reset_trap_pkg::SEL_PUSHJ :
	                       (is_cond && test_ok) ? reset_trap_pkg::SEL_JUMP : reset_trap_pkg::SEL_NEXT;
	wire        carry_d  = trap ? reset_trap_pkg::TRAP_CARRY : reset_trap_pkg::SEQ_CARRY;
	wire [8:0]  addr_inc = addr_q + 9'h001;

	// Address generator with one return entry; it runs through the trap, power reset clears the address but keeps the return entry.
	always_ff @(posedge clk_sys_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			addr_q     <= reset_trap_pkg::ADDR_ZERO;
			stack_q    <= reset_trap_pkg::ADDR_ZERO;
			sel_code_q <= reset_trap_pkg::SEL_NEXT;
			carry_q    <= reset_trap_pkg::SEQ_CARRY;
		end else begin
			sel_code_q <= sel_d;
			carry_q    <= carry_d;
			if (pr_active) begin
				addr_q <= reset_trap_pkg::ADDR_ZERO;
			end else begin
				case (sel_d)
					reset_trap_pkg::SEL_TRAP: begin
						stack_q <= addr_q;
						addr_q  <= next_microaddress;
					end
					reset_trap_pkg::SEL_PUSHJ: begin
						stack_q <= addr_inc;
						addr_q  <= next_microaddress;
					end
					reset_trap_pkg::SEL_JUMP: addr_q <= next_microaddress;
					reset_trap_pkg::SEL_POP:  addr_q <= stack_q;
					default:                  addr_q <= addr_inc;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Datapath byte clocks. Gating them alone keeps the sequencer stepping through the trap.
	wire        dp_enable = !trap && !clock_stop_bit_in && !pr_active;

	always_ff @(posedge clk_sys_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			left_n_q  <= 1'b1;
			right_n_q <= 1'b1;
			func_q    <= 7'h00;
		end else begin
			left_n_q  <= !dp_enable;
			right_n_q <= !dp_enable;
			if (dp_enable) begin
				func_q <= datapath_function_code_in;
			end
		end
	end

	// Interface reset is set straight from the I/O reset pin, so it needs no clock edge.
	always_ff @(posedge clk_sys_in or negedge io_reset_n_in) begin
		if (!io_reset_n_in) begin
			gir_q <= 1'b1;
		end else begin
			gir_q <= pr_active;
		end
	end

	// Drive controls go safe as soon as the power reset pin falls.
	always_ff @(posedge clk_sys_in or negedge power_reset_n_in) begin
		if (!power_reset_n_in) begin
			safe_q <= 1'b1;
		end else begin
			safe_q <= gir_q || pr_active;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Wishbone slave: one wait state, unmapped words read zero and ignore writes.
	wire        wb_req   = wb_cyc_in && wb_stb_in && !ack_q;
	wire        wb_wr    = wb_req && wb_we_in;
	wire        hit_ctrl = (wb_adr_in == reset_trap_pkg::REG_CTRL);
	wire        hit_stat = (wb_adr_in == reset_trap_pkg::REG_STATUS);
	wire        clr_abn  = wb_wr && hit_stat && wb_sel_in[0] && wb_dat_in[reset_trap_pkg::ST_ABNORMAL];
	wire [31:0] status_v = {7'h00, addr_q, 13'h0000, !abort_latched_n_q, routine_q, abnormal_q};
	wire [31:0] ctrl_v   = {31'h00000000, jumper_q};
	wire [31:0] rdata_d  = hit_ctrl ? ctrl_v : (hit_stat ? status_v : 32'h00000000);

	always_ff @(posedge clk_sys_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ack_q    <= 1'b0;
			rdata_q  <= 32'h00000000;
			jumper_q <= reset_trap_pkg::CTRL_RESET;
		end else begin
			ack_q <= wb_req;
			if (wb_req) begin
				rdata_q <= rdata_d;
			end
			if (wb_wr && hit_ctrl && wb_sel_in[0]) begin
				jumper_q <= wb_dat_in[reset_trap_pkg::CTRL_JUMPER];
			end
		end
	end

	// Abnormal completion is sticky; an abort trap in the clearing cycle keeps it set.
	always_ff @(posedge clk_sys_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			abnormal_q <= 1'b0;
			routine_q  <= 1'b0;
		end else begin
			if (abort_trap) begin
				abnormal_q <= 1'b1;
			end else if (clr_abn) begin
				abnormal_q <= 1'b0;
			end
			if (abort_trap) begin
				routine_q <= 1'b1;
			end else if (addr_q == reset_trap_pkg::IDLE_ADDR) begin
				routine_q <= 1'b0;
			end
		end
	end

	// Output drive, all from flip-flops.
	assign wb_ack_out                      = ack_q;
	assign wb_dat_out                      = rdata_q;
	assign microprogram_address_out        = addr_q;
	assign sequencer_select_code_out       = sel_code_q;
	assign sequencer_carry_in_out          = carry_q;
	assign datapath_left_byte_clock_n_out  = left_n_q;
	assign datapath_right_byte_clock_n_out = right_n_q;
	assign datapath_function_code_out      = func_q;
	assign general_interface_reset_b_out   = gir_q;
	assign device_ctrl_safe_out            = safe_q;
	assign interrupt_latch_clear_n_out     = interrupt_latch_clear_n_q;
	assign clock_quiet_window_out          = clock_quiet_window_q;

	////////////////////////////////////////////////////////////////////////////////
	// Checks on the trap path and the clock gating.
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_q);

	AST_TRAP_ONE_CYCLE: assert property (trap && !pr_active ##1 !pr_active |-> !trap)
		else $error("trap lasted more than one clock");
	AST_TRAP_VECTOR: assert property (trap && !pr_active |=> addr_q == {2'h0, $past(interrupt_vector_code), 4'h0})
		else $error("trap did not jump to its vector");
	AST_TRAP_SELECT: assert property (trap |=> sel_code_q == 6'h2c && !carry_q)
		else $error("trap select code wrong");
	AST_TRAP_PUSH: assert property (trap && !pr_active |=> stack_q == $past(addr_q))
		else $error("trap did not push the address");
	AST_DP_SUPPRESS: assert property (trap |=> left_n_q && right_n_q)
		else $error("datapath clocked during trap");
	AST_DP_REENABLE: assert property (trap && !pr_active ##1 (!trap && !clock_stop_bit_in && !pr_active) |=> !left_n_q && !right_n_q)
		else $error("datapath not re-enabled after jump");
	AST_STOP_BIT: assert property (clock_stop_bit_in |=> left_n_q && right_n_q)
		else $error("clock stop bit ignored");
	AST_ABNORMAL: assert property (abort_trap |=> abnormal_q [*2])
		else $error("abnormal completion not set");
	AST_PR_HOLD: assert property (pr_active |=> addr_q == 9'h000)
		else $error("power reset did not hold vector zero");
	AST_PRIO: assert property (!abort_synced_n_q |-> interrupt_vector_code == 3'h0)
		else $error("abort lost priority");
	AST_SYNC_PATH: assert property ($fell(abort_latched_n_q) |=> !abort_synced_n_q ##1 trap || !trap_release_stage_n_q || pr_active)
		else $error("abort did not reach the encoder");
	AST_SAFE: assert property (pr_active |-> safe_q)
		else $error("drive controls not safe in power reset");

	COV_ABORT_TRAP: cover property (abort_trap && !pr_active ##1 !trap);
	COV_PR_RELEASE: cover property (pr_active ##1 !pr_active && trap);
	COV_LATCH_CLEAR: cover property (!interrupt_latch_clear_n_q ##2 !encoder_group_select);
	COV_JUMPER: cover property (branch_ctrl_in == reset_trap_pkg::BR_JUMPER && jumper_q && !trap);

endmodule

// ==== tb/reset_host_model.sv ====
// Backplane host and power supply model that drives the three reset pins of the sequencer.
`timescale 1ns/100ps
module reset_host_model #(
	parameter int IO_PULSE_CYCLES = 7,   // 280 ns at 40 ns, inside the legal pulse width.
	parameter int LEAD_CYCLES     = 250  // 10 us of power reset ahead of the supplies dropping.
) (
	input  wire logic clk_in,                    // Clock that paces the model.
	output logic      power_reset_n_out,         // Power reset, active low.
	output logic      power_fail_warning_n_out,  // Power-fail warning, active low.
	output logic      io_reset_n_out             // I/O reset pulse, active low.
);
	// All pins rest high; the supply is up and the host is running.
	initial begin
		power_reset_n_out = 1'h1;
		power_fail_warning_n_out = 1'h1;
		io_reset_n_out = 1'h1;
	end
	////////////////////////////////////////////////////////////////////////////////
	// One low pulse per reset instruction; the width is fixed so it never leaves the legal window.
	task automatic io_pulse();
		io_reset_n_out <= 1'h0;
		repeat (IO_PULSE_CYCLES) @(posedge clk_in);
		io_reset_n_out <= 1'h1;
	endtask
	// The warning goes low early and stays low until the power reset is released.
	task automatic warn();
		power_fail_warning_n_out <= 1'h0;
	endtask
	// Reset covers the lead time plus the off period, so it is low well before the supplies drop and until they come back.
	task automatic power_cycle(input int off_cycles);
		power_reset_n_out <= 1'h0;
		repeat (LEAD_CYCLES + off_cycles) @(posedge clk_in);
		power_reset_n_out <= 1'h1;
		power_fail_warning_n_out <= 1'h1;
	endtask
endmodule

// ==== tb/test_reset_trap_sequencer.sv ====
// Self-checking bench for the reset trap sequencer driven by the backplane model.
`timescale 1ns/100ps
module test_reset_trap_sequencer;
	typedef struct {
		logic [2:0] b;
		logic [8:0] n;
		logic       t;
		logic [8:0] e;
	} row_t;
	logic        clk, rstn, cyc, stb, we, tbit, stop, q;
	logic        ack, lclk, rclk, gir, safe, clr_n, quiet, carry;
	logic [3:0]  irq, sel;
	logic [6:0]  func, fout;
	logic [2:0]  br;
	logic [8:0]  nra, addr;
	logic [5:0]  scode;
	logic [7:0]  adr;
	logic [31:0] wdat, rdat, ack_dat;
	wire         pr_n, pfw_n, io_n;
	int          fails, compares, clrs, i, n;
	row_t        rows [8];
	localparam logic [8:0] IDLE = reset_trap_pkg::IDLE_ADDR;

	reset_host_model far (.clk_in(clk), .power_reset_n_out(pr_n), .power_fail_warning_n_out(pfw_n),
		.io_reset_n_out(io_n));
	reset_trap_sequencer uut (.clk_sys_in(clk), .rstn_in(rstn), .power_reset_n_in(pr_n),
		.power_fail_warning_n_in(pfw_n), .io_reset_n_in(io_n), .irq_in(irq), .clock_stop_bit_in(stop),
		.datapath_function_code_in(func), .branch_ctrl_in(br), .nra_field_in(nra), .test_bit_in(tbit),
		.wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
		.wb_ack_out(ack), .wb_dat_out(ack_dat), .microprogram_address_out(addr),
		.sequencer_select_code_out(scode), .sequencer_carry_in_out(carry),
		.datapath_left_byte_clock_n_out(lclk), .datapath_right_byte_clock_n_out(rclk),
		.datapath_function_code_out(fout), .general_interface_reset_b_out(gir), .device_ctrl_safe_out(safe),
		.interrupt_latch_clear_n_out(clr_n), .clock_quiet_window_out(quiet));

	////////////////////////////////////////////////////////////////////////////////
	// Free-running clock, latch-clear pulse counter and a watchdog so a hang still ends the run.
	initial begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) if (clr_n === 1'h0) clrs++;
	initial begin
		#(40 * 6000);
		fails++;
		close_out();
	end

	////////////////////////////////////////////////////////////////////////////////
	// Shared comparison, bus cycle, microword drive and wait helpers.
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// The request is held until ack is sampled high; the trailing release leaves cyc low for a cycle.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		wdat <= d;
		while (ack !== 1'h1) @(posedge clk);
		rdat = ack_dat;
		cyc <= 1'h0;
		stb <= 1'h0;
	endtask
	task automatic md(input logic [2:0] b, input logic [8:0] a, input logic t);
		br <= b;
		nra <= a;
		tbit <= t;
	endtask
	task automatic wait_addr(input logic [8:0] a);
		for (n = 0; n < 30 && addr !== a; n++) begin
			@(posedge clk);
			#1;
		end
		check("address", addr, a);
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", compares, fails);
		if (fails == 0 && compares > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence: reset, table of branch cases, then traps and the bus registers.
	initial begin
		{rstn, cyc, stb, we, tbit, stop} = 6'h00;
		{irq, func, br, nra, adr, wdat} = '0;
		sel = 4'hf;
		{fails, compares, clrs} = '0;
		rows = '{'{reset_trap_pkg::BR_JUMP, 9'h050, 1'h0, 9'h050}, '{reset_trap_pkg::BR_CONTINUE, 9'h000, 1'h0, 9'h051},
			'{reset_trap_pkg::BR_COND, 9'h100, 1'h0, 9'h052}, '{reset_trap_pkg::BR_COND, 9'h100, 1'h1, 9'h100},
			'{reset_trap_pkg::BR_CALL, 9'h180, 1'h0, 9'h180}, '{reset_trap_pkg::BR_JUMPER, 9'h020, 1'h0, 9'h181},
			'{reset_trap_pkg::BR_RETURN, 9'h000, 1'h0, 9'h101}, '{reset_trap_pkg::BR_JUMP, IDLE, 1'h0, IDLE}};
		repeat (3) @(posedge clk);
		#1 check("address", addr, 9'h000);
		check("select", scode, reset_trap_pkg::SEL_NEXT);
		check("byte clock", {lclk, rclk}, 2'h3);
		check("ack", ack, 1'h0);
		check("latch clear", clr_n, 1'h1);
		repeat (2) @(posedge clk);
		rstn <= 1'h1;
		repeat (5) @(posedge clk);
		wb(1'h0, reset_trap_pkg::REG_CTRL, 32'h0);
		check("ctrl reset", rdat, 32'h0);
		wb(1'h0, 8'h10, 32'h0);
		check("unmapped", rdat, 32'h0);
		@(posedge clk);
		md(rows[0].b, rows[0].n, rows[0].t);
		for (i = 0; i < 8; i++) begin
			@(posedge clk);
			if (i < 7) md(rows[i + 1].b, rows[i + 1].n, rows[i + 1].t);
			#1 check("address", addr, rows[i].e);
		end
		wb(1'h1, reset_trap_pkg::REG_CTRL, 32'h1);
		@(posedge clk);
		md(reset_trap_pkg::BR_JUMPER, 9'h020, 1'h0);
		@(posedge clk);
		md(reset_trap_pkg::BR_JUMP, IDLE, 1'h0);
		#1 check("address", addr, 9'h020);
		wb(1'h0, reset_trap_pkg::REG_CTRL, 32'h0);
		check("ctrl", rdat, 32'h1);
		@(posedge clk);
		func <= 7'h5a;
		repeat (3) @(posedge clk);
		#1 check("function", fout, 7'h5a);
		check("byte clock", {lclk, rclk}, 2'h0);
		@(posedge clk);
		stop <= 1'h1;
		@(posedge clk);
		stop <= 1'h0;
		i = 0;
		repeat (4) begin
			#1 if ((lclk & rclk) === 1'h1) i++;
			@(posedge clk);
		end
		check("stopped cycles", i, 1);
		// A host reset pulse: interface reset at once, then one trap cycle and on to the idle loop.
		clrs = 0;
		@(posedge clk);
		fork
			far.io_pulse();
			begin
				#1 check("interface reset", gir, 1'h1);
				wait_addr(9'h000);
				check("select", scode, reset_trap_pkg::SEL_TRAP);
				check("carry", carry, reset_trap_pkg::TRAP_CARRY);
				check("byte clock", {lclk, rclk}, 2'h3);
				q = quiet;
				@(posedge clk);
				#1 check("address", addr, IDLE);
				check("byte clock", {lclk, rclk}, 2'h0);
				check("quiet", quiet, !q);
			end
		join
		repeat (6) @(posedge clk);
		#1 check("interface reset", gir, 1'h0);
		check("latch clear pulses", clrs, 1);
		wb(1'h0, reset_trap_pkg::REG_STATUS, 32'h0);
		check("status", rdat, {7'h00, IDLE, 16'h0001});
		wb(1'h1, reset_trap_pkg::REG_STATUS, 32'h1);
		wb(1'h0, reset_trap_pkg::REG_STATUS, 32'h0);
		check("abnormal", rdat[0], 1'h0);
		for (i = 0; i < 4; i++) begin
			@(posedge clk);
			irq <= 4'h1 << i;
			wait_addr(9'(16 * (i + 1)));
			@(posedge clk);
			irq <= 4'h0;
			repeat (6) @(posedge clk);
		end
		// Warning beside a lower source: the warning wins, and holding it does not trap again.
		@(posedge clk);
		far.warn();
		// The warning needs four edges to reach the encoder; the lower source joins it there.
		repeat (4) @(posedge clk);
		irq <= 4'h1;
		wait_addr(9'h000);
		check("interface reset", gir, 1'h0);
		@(posedge clk);
		irq <= 4'h0;
		i = 0;
		repeat (10) begin
			@(posedge clk);
			#1 if (addr !== IDLE) i++;
		end
		check("retrap cycles", i, 0);
		// Clear the abnormal bit so that only the power reset can set it again.
		wb(1'h1, reset_trap_pkg::REG_STATUS, 32'h1);
		@(posedge clk);
		fork
			far.power_cycle(50);
			begin
				#1 check("safe", safe, 1'h1);
				repeat (5) @(posedge clk);
				#1 check("address", addr, 9'h000);
				check("byte clock", {lclk, rclk}, 2'h3);
			end
		join
		wait_addr(IDLE);
		check("safe", safe, 1'h0);
		wb(1'h0, reset_trap_pkg::REG_STATUS, 32'h0);
		check("abnormal", rdat[0], 1'h1);
		close_out();
	end
endmodule
